// ==== design/deeac_consts.svh ====
// offsets, field positions, key values and timing counts of the data eeprom access controller
`ifndef DEEAC_CONSTS_SVH
`define DEEAC_CONSTS_SVH

// ***********************************
// register indices (byte address = index * 4)
// ***********************************
`define DEEAC_IDX_CTL       14'h0fa6
`define DEEAC_IDX_KEY       14'h0fa7
`define DEEAC_IDX_DATA      14'h0fa8
`define DEEAC_IDX_ADRL      14'h0fa9
`define DEEAC_IDX_ADRH      14'h0faa
`define DEEAC_IDX_IRQ_STAT  14'h0fab
`define DEEAC_IDX_IRQ_MASK  14'h0fac

// ***********************************
// control register fields
// ***********************************
`define DEEAC_CTL_RD        0
`define DEEAC_CTL_WR        1
`define DEEAC_CTL_PERMIT    2
`define DEEAC_CTL_ABORT     3
`define DEEAC_CTL_FREE      4
`define DEEAC_CTL_CFGSEL    6
`define DEEAC_CTL_PGMSEL    7
`define DEEAC_CTL_RW_MASK   8'hdc

// ***********************************
// interrupt status / mask fields
// ***********************************
`define DEEAC_IRQ_DONE      0
`define DEEAC_IRQ_ABORT     1
`define DEEAC_IRQ_W         2

// ***********************************
// misc values
// ***********************************
`define DEEAC_KEY_FIRST     8'h55
`define DEEAC_KEY_SECOND    8'haa
`define DEEAC_ADRH_MASK     8'h03
`define DEEAC_ADDR_W        10
`define DEEAC_DEPTH         1024
`define DEEAC_WRITE_CYCLES  500000
`define DEEAC_SYNC_STAGES   3

`endif

// ==== design/deeac_pkg.sv ====
// types shared by the data eeprom access controller
package deeac_pkg;

	typedef enum logic [1:0] {
		UNL_IDLE,
		UNL_GOT_FIRST,
		UNL_ARMED
	} deeac_unlock_e;

	typedef enum logic {
		WS_IDLE,
		WS_BUSY
	} deeac_wstate_e;

endpackage

// ==== design/deeac_array.sv ====
// 1024 x 8 data array held in flip-flops
`timescale 1ns/1ps
`include "deeac_consts.svh"

module deeac_array (
	// clock
	input  wire logic                       ref_clk,
	// write port
	input  wire logic                       wr_en,
	input  wire logic [`DEEAC_ADDR_W-1:0]   wr_addr,
	input  wire logic [7:0]                 wr_data,
	// read port, combinational
	input  wire logic [`DEEAC_ADDR_W-1:0]   rd_addr,
	output logic      [7:0]                 rd_data
);

	// ***********************************
	// storage
	// ***********************************
	// no reset: contents are nonvolatile across every reset
	logic [7:0] mem_q [`DEEAC_DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem_q[rd_addr];

endmodule

// ==== design/deeac_unlock.sv ====
// tracker of the two-byte write unlock sequence
`timescale 1ns/1ps
`include "deeac_consts.svh"

module deeac_unlock (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// accepted register writes
	input  wire logic        wr_any,
	input  wire logic        key_hit,
	input  wire logic [7:0]  wr_byte,
	// sequence state
	output logic             armed
);

	deeac_pkg::deeac_unlock_e st_q;
	deeac_pkg::deeac_unlock_e st_d;

	// ***********************************
	// next state
	// ***********************************
	// any other write breaks the sequence, so the arming is used up by the very next write
	always_comb begin
		st_d = st_q;
		if (wr_any) begin
			if (key_hit && wr_byte == `DEEAC_KEY_FIRST) begin
				st_d = deeac_pkg::UNL_GOT_FIRST;
			end else if (key_hit && wr_byte == `DEEAC_KEY_SECOND
					&& st_q == deeac_pkg::UNL_GOT_FIRST) begin
				st_d = deeac_pkg::UNL_ARMED;
			end else begin
				st_d = deeac_pkg::UNL_IDLE;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= deeac_pkg::UNL_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	always_comb begin
		case (st_q)
			deeac_pkg::UNL_ARMED: armed = 1'b1;
			default:              armed = 1'b0;
		endcase
	end

endmodule

// ==== design/deeac_top.sv ====
// data eeprom access controller: wishbone registers, read/write engine, resets, interrupt
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "deeac_consts.svh"

module deeac_top #(
	parameter int unsigned WRITE_CYCLES = `DEEAC_WRITE_CYCLES
) (
	// clock and power-up reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// wishbone slave
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [15:0]  wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic      [31:0]  wb_dat_o,
	output logic              wb_ack_o,
	// asynchronous reset sources
	input  wire logic         external_reset_pin,
	input  wire logic         watchdog_timer_rst,
	// interrupt
	output logic              irq_o
);

	// ***********************************
	// decode helper
	// ***********************************
	function automatic logic reg_hit(input logic [15:0] adr, input logic [13:0] idx);
		reg_hit = (adr[15:2] == idx);
	endfunction

	// ***********************************
	// reset source synchronisers
	// ***********************************
	logic [1:0] rst_src;
	logic [1:0] rst_flt_q;
	logic       soft_rst;

	assign rst_src = {watchdog_timer_rst, external_reset_pin};

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_sync
			logic [`DEEAC_SYNC_STAGES-1:0] sy_q;
			logic [`DEEAC_SYNC_STAGES-1:0] sy_d;
			logic                          flt_d;
			// level only accepted once second and third stage agree
			always_comb begin
				sy_d  = {sy_q[1:0], rst_src[g]};
				flt_d = (sy_q[2] == sy_q[1]) ? sy_q[2] : rst_flt_q[g];
			end
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					sy_q         <= 3'h0;
					rst_flt_q[g] <= 1'b0;
				end else begin
					sy_q         <= sy_d;
					rst_flt_q[g] <= flt_d;
				end
			end
		end
	endgenerate

	assign soft_rst = |rst_flt_q;

	// ***********************************
	// state
	// ***********************************
	logic [7:0]                  ctl_q, ctl_d;
	logic [7:0]                  dat_q, dat_d;
	logic [7:0]                  adl_q, adl_d;
	logic [1:0]                  adh_q, adh_d;
	logic [`DEEAC_IRQ_W-1:0]     stat_q, stat_d;
	logic [`DEEAC_IRQ_W-1:0]     mask_q, mask_d;
	logic [31:0]                 cnt_q, cnt_d;
	deeac_pkg::deeac_wstate_e    ws_q, ws_d;
	logic                        ack_d;
	logic [31:0]                 rdat_d;
	logic                        irq_d;

	// ***********************************
	// bus strobes
	// ***********************************
	logic        req;
	logic        wr;
	logic [7:0]  wbyte;
	logic        hit_ctl;
	logic        hit_key;
	logic        hit_dat;
	logic        hit_adl;
	logic        hit_adh;
	logic        hit_stat;
	logic        hit_mask;

	// one request per ack; ack drops the cycle after it is given
	assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr       = req & wb_we_i & wb_sel_i[0];
	assign wbyte    = wb_dat_i[7:0];
	assign hit_ctl  = reg_hit(wb_adr_i, `DEEAC_IDX_CTL);
	assign hit_key  = reg_hit(wb_adr_i, `DEEAC_IDX_KEY);
	assign hit_dat  = reg_hit(wb_adr_i, `DEEAC_IDX_DATA);
	assign hit_adl  = reg_hit(wb_adr_i, `DEEAC_IDX_ADRL);
	assign hit_adh  = reg_hit(wb_adr_i, `DEEAC_IDX_ADRH);
	assign hit_stat = reg_hit(wb_adr_i, `DEEAC_IDX_IRQ_STAT);
	assign hit_mask = reg_hit(wb_adr_i, `DEEAC_IDX_IRQ_MASK);

	// ***********************************
	// submodules
	// ***********************************
	logic                      armed;
	logic                      arr_we;
	logic [`DEEAC_ADDR_W-1:0]  cur_addr;
	logic [7:0]                arr_rd;

	assign cur_addr = {adh_q, adl_q};

	deeac_unlock u_deeac_unlock (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr_any  (wr),
		.key_hit (hit_key),
		.wr_byte (wbyte),
		.armed   (armed)
	);

	deeac_array u_deeac_array (
		.ref_clk (ref_clk),
		.wr_en   (arr_we),
		.wr_addr (cur_addr),
		.wr_data (dat_q),
		.rd_addr (cur_addr),
		.rd_data (arr_rd)
	);

	// ***********************************
	// next state
	// ***********************************
	logic                    busy;
	logic                    done_ev;
	logic                    abort_ev;
	logic [7:0]              ctl_rd;
	logic [7:0]              adh_rd;

	always_comb begin
		ctl_d    = ctl_q;
		dat_d    = dat_q;
		adl_d    = adl_q;
		adh_d    = adh_q;
		stat_d   = stat_q;
		mask_d   = mask_q;
		cnt_d    = cnt_q;
		ws_d     = ws_q;
		arr_we   = 1'b0;
		done_ev  = 1'b0;
		abort_ev = 1'b0;
		busy     = (ws_q == deeac_pkg::WS_BUSY);
		ack_d    = req;
		ctl_rd   = ctl_q & 8'hdf;
		adh_rd   = {6'h00, adh_q};

		// self-timed erase-and-program cycle
		if (busy) begin
			if (cnt_q == 32'h0) begin
				arr_we          = 1'b1;
				ctl_d[`DEEAC_CTL_WR] = 1'b0;
				ws_d            = deeac_pkg::WS_IDLE;
				done_ev         = 1'b1;
			end else begin
				cnt_d = cnt_q - 32'h1;
			end
		end

		// control, address and data frozen while a write runs
		if (wr && !busy) begin
			if (hit_ctl) begin
				// set-only start bits: written zeros are ignored
				ctl_d = (ctl_q & ~8'(`DEEAC_CTL_RW_MASK)) | (wbyte & 8'(`DEEAC_CTL_RW_MASK));
				if (wbyte[`DEEAC_CTL_RD] && !wbyte[`DEEAC_CTL_PGMSEL]
						&& !wbyte[`DEEAC_CTL_CFGSEL]) begin
					// array is flops, so the byte lands with the write itself
					dat_d = arr_rd;
				end
				// permit must already be set; the unlock must be the two writes just before
				if (wbyte[`DEEAC_CTL_WR] && ctl_q[`DEEAC_CTL_PERMIT] && armed
						&& !wbyte[`DEEAC_CTL_PGMSEL] && !wbyte[`DEEAC_CTL_CFGSEL]) begin
					ctl_d[`DEEAC_CTL_WR] = 1'b1;
					ws_d  = deeac_pkg::WS_BUSY;
					cnt_d = 32'(WRITE_CYCLES) - 32'h1;
				end
			end
			if (hit_dat) begin
				dat_d = wbyte;
			end
			if (hit_adl) begin
				adl_d = wbyte;
			end
			if (hit_adh) begin
				adh_d = wbyte[1:0];
			end
		end

		// status and mask stay writable during a cycle; key writes go to the tracker only
		if (wr && hit_stat) begin
			stat_d = stat_q & ~wbyte[`DEEAC_IRQ_W-1:0];
		end
		if (wr && hit_mask) begin
			mask_d = wbyte[`DEEAC_IRQ_W-1:0];
		end

		// pin or watchdog reset: abandon cycle, array keeps old byte
		if (soft_rst) begin
			if (busy) begin
				ctl_d[`DEEAC_CTL_ABORT] = 1'b1;
				abort_ev = 1'b1;
			end
			ctl_d[`DEEAC_CTL_WR]   = 1'b0;
			ctl_d[`DEEAC_CTL_RD]   = 1'b0;
			ctl_d[`DEEAC_CTL_PERMIT] = 1'b0;
			ctl_d[`DEEAC_CTL_FREE] = 1'b0;
			ws_d   = deeac_pkg::WS_IDLE;
			arr_we = 1'b0;
			done_ev = 1'b0;
			dat_d  = 8'h00;
			adl_d  = 8'h00;
			adh_d  = 2'h0;
		end

		// hardware set wins over a clear in the same cycle
		stat_d[`DEEAC_IRQ_DONE]  = stat_d[`DEEAC_IRQ_DONE] | done_ev;
		stat_d[`DEEAC_IRQ_ABORT] = stat_d[`DEEAC_IRQ_ABORT] | abort_ev;
		irq_d = |(stat_d & mask_d);

		// read mux; unmapped addresses answer zero
		rdat_d = 32'h0;
		if (req && !wb_we_i) begin
			if (hit_ctl) begin
				rdat_d = {24'h0, ctl_rd};
			end else if (hit_key) begin
				rdat_d = 32'h0;
			end else if (hit_dat) begin
				rdat_d = {24'h0, dat_q};
			end else if (hit_adl) begin
				rdat_d = {24'h0, adl_q};
			end else if (hit_adh) begin
				rdat_d = {24'h0, adh_rd};
			end else if (hit_stat) begin
				rdat_d = {30'h0, stat_q};
			end else if (hit_mask) begin
				rdat_d = {30'h0, mask_q};
			end
		end
	end

	// ***********************************
	// registers
	// ***********************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctl_q    <= 8'h00;
			dat_q    <= 8'h00;
			adl_q    <= 8'h00;
			adh_q    <= 2'h0;
			stat_q   <= 2'h0;
			mask_q   <= 2'h0;
			cnt_q    <= 32'h0;
			ws_q     <= deeac_pkg::WS_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			irq_o    <= 1'b0;
		end else begin
			ctl_q    <= ctl_d;
			dat_q    <= dat_d;
			adl_q    <= adl_d;
			adh_q    <= adh_d;
			stat_q   <= stat_d;
			mask_q   <= mask_d;
			cnt_q    <= cnt_d;
			ws_q     <= ws_d;
			wb_ack_o <= ack_d;
			wb_dat_o <= rdat_d;
			irq_o    <= irq_d;
		end
	end

endmodule

// ==== tb/deeac_checker.sv ====
// port-level assertions for the eeprom access controller
`timescale 1ns/1ps
`include "deeac_consts.svh"

module deeac_checker #(
	parameter int unsigned WRITE_CYCLES = 5
) (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// resets and interrupt
	input wire logic        external_reset_pin,
	input wire logic        watchdog_timer_rst,
	input wire logic        irq_o
);
	// ***********************************
	// helpers
	// ***********************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire logic        tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic        rd = tk & ~wb_we_i;
	wire logic [13:0] ix = wb_adr_i[15:2];
	wire logic        rs = external_reset_pin | watchdog_timer_rst;
	// a status or mask write moves irq one edge later
	wire logic        wi = tk & wb_we_i & wb_sel_i[0]
		& (ix == `DEEAC_IDX_IRQ_STAT | ix == `DEEAC_IDX_IRQ_MASK);

	property p_ack; tk |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_key; rd & ix == `DEEAC_IDX_KEY |=> wb_dat_o == 32'h0; endproperty
	a_key: assert property (p_key) else $error("key not zero");
	property p_adrh; rd & ix == `DEEAC_IDX_ADRH |=> wb_dat_o[7:2] == 6'h00; endproperty
	a_adrh: assert property (p_adrh) else $error("adrh upper set");
	property p_ctl;
		rd & ix == `DEEAC_IDX_CTL |=> wb_dat_o[5] == 1'b0 && wb_dat_o[0] == 1'b0;
	endproperty
	a_ctl: assert property (p_ctl) else $error("ctl bits set");
	property p_mask;
		wb_we_i & tk & wb_sel_i[0] & ix == `DEEAC_IDX_IRQ_MASK & wb_dat_i[1:0] == 2'b00
			|-> ##2 !irq_o;
	endproperty
	a_mask: assert property (p_mask) else $error("irq despite mask");
	property p_hold; irq_o & ~wi & ~$past(wi) |=> irq_o; endproperty
	a_hold: assert property (p_hold) else $error("irq dropped");
	property p_abort;
		rs [*6] ##1 (rs & rd & ix == `DEEAC_IDX_DATA) |=> wb_dat_o[7:0] == 8'h00;
	endproperty
	a_abort: assert property (p_abort) else $error("data kept in reset");
endmodule

// ==== tb/tb_deeac_top.sv ====
// self-checking bench for the eeprom access controller
`timescale 1ns/1ps
`include "deeac_consts.svh"
`define CMP(n, e, s) begin comparisons++; if ((e) !== (s)) begin n_mismatch++; \
	$display("ERROR %s expected %h seen %h", n, e, s); end end

module tb_deeac_top;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [15:0] wb_adr_i = 16'h0000;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        external_reset_pin = 1'b0;
	logic        watchdog_timer_rst = 1'b0;
	logic        irq_o;
	logic [31:0] exq[$];
	string       nmq[$];
	logic [31:0] en;
	string       nm;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          n;
	logic [7:0]  v;

	// long enough that a reset lands mid-write
	deeac_top #(.WRITE_CYCLES(20)) u_deeac_top (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.external_reset_pin, .watchdog_timer_rst, .irq_o);

	always #4 ref_clk = ~ref_clk;

	task automatic report_and_stop;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// hang guard, far above the few hundred cycles needed
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			report_and_stop;
		end
	end

	always @(posedge ref_clk) begin
		if (wb_ack_o === 1'b1 && !wb_we_i && exq.size() > 0) begin
			en = exq.pop_front();
			nm = nmq.pop_front();
			`CMP(nm, en, wb_dat_o)
		end
	end

	task automatic bus(input logic [13:0] i, input logic w, input logic [7:0] d,
			input logic [3:0] s);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {i, 2'b00};
		wb_sel_i <= s;
		wb_dat_i <= {24'($urandom()), d};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [13:0] i, input logic [7:0] d);
		bus(i, 1'b1, d, 4'hf);
	endtask

	task automatic rd(input logic [13:0] i, input logic [7:0] e, input string s);
		exq.push_back({24'h0, e});
		nmq.push_back(s);
		bus(i, 1'b0, 8'h00, 4'hf);
	endtask

	task automatic go;
		wr(`DEEAC_IDX_KEY, 8'h55);
		wr(`DEEAC_IDX_KEY, 8'haa);
		wr(`DEEAC_IDX_CTL, 8'h06);
	endtask

	// ***********************************
	// stimulus
	// ***********************************
	initial begin
		v = 8'($urandom(46));
		// never zero, so a cleared data register is told apart from the array byte
		v = 8'($urandom()) | 8'h01;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(`DEEAC_IDX_CTL, 8'h00, "ctl");
		wr(`DEEAC_IDX_KEY, 8'h55);
		rd(`DEEAC_IDX_KEY, 8'h00, "key");
		wr(`DEEAC_IDX_ADRH, 8'hff);
		rd(`DEEAC_IDX_ADRH, 8'h03, "adrh");
		rd(14'h0fb0, 8'h00, "unmapped");
		wr(`DEEAC_IDX_ADRL, 8'hff);
		wr(`DEEAC_IDX_DATA, v);
		wr(`DEEAC_IDX_IRQ_MASK, 8'h01);
		wr(`DEEAC_IDX_CTL, 8'h06);
		rd(`DEEAC_IDX_CTL, 8'h04, "ctl");
		wr(`DEEAC_IDX_KEY, 8'haa);
		wr(`DEEAC_IDX_KEY, 8'h55);
		wr(`DEEAC_IDX_CTL, 8'h06);
		rd(`DEEAC_IDX_CTL, 8'h04, "ctl");
		go();
		rd(`DEEAC_IDX_CTL, 8'h06, "busy");
		wr(`DEEAC_IDX_DATA, ~v);
		n = 0;
		while (irq_o !== 1'b1 && n < 60) begin
			@(posedge ref_clk);
			n++;
		end
		`CMP("irq", 1'b1, irq_o)
		// 20-cycle write less the six edges spent on the two bus calls after the start
		`CMP("wait", 14, n)
		rd(`DEEAC_IDX_CTL, 8'h04, "ctl");
		rd(`DEEAC_IDX_IRQ_STAT, 8'h01, "stat");
		rd(`DEEAC_IDX_DATA, v, "data");
		wr(`DEEAC_IDX_IRQ_STAT, 8'h01);
		rd(`DEEAC_IDX_IRQ_STAT, 8'h00, "stat");
		`CMP("irq", 1'b0, irq_o)
		wr(`DEEAC_IDX_DATA, 8'h00);
		bus(`DEEAC_IDX_DATA, 1'b1, 8'h5a, 4'he);
		rd(`DEEAC_IDX_DATA, 8'h00, "data");
		wr(`DEEAC_IDX_CTL, 8'h01);
		rd(`DEEAC_IDX_DATA, v, "array");
		wr(`DEEAC_IDX_DATA, 8'h00);
		wr(`DEEAC_IDX_CTL, 8'h81);
		rd(`DEEAC_IDX_CTL, 8'h80, "ctl");
		rd(`DEEAC_IDX_DATA, 8'h00, "data");
		wr(`DEEAC_IDX_CTL, 8'h41);
		rd(`DEEAC_IDX_CTL, 8'h40, "ctl");
		rd(`DEEAC_IDX_DATA, 8'h00, "data");
		wr(`DEEAC_IDX_IRQ_MASK, 8'h00);
		// both reset sources, each while a write is running
		for (int k = 0; k < 2; k++) begin
			wr(`DEEAC_IDX_ADRL, v);
			wr(`DEEAC_IDX_DATA, v);
			wr(`DEEAC_IDX_CTL, 8'h04);
			go();
			{external_reset_pin, watchdog_timer_rst} <= k[0] ? 2'b10 : 2'b01;
			repeat (8) @(posedge ref_clk);
			rd(`DEEAC_IDX_DATA, 8'h00, "data");
			{external_reset_pin, watchdog_timer_rst} <= 2'b00;
			repeat (6) @(posedge ref_clk);
			rd(`DEEAC_IDX_ADRL, 8'h00, "adrl");
			rd(`DEEAC_IDX_CTL, 8'h08, "ctl");
			rd(`DEEAC_IDX_IRQ_STAT, 8'h02, "stat");
			wr(`DEEAC_IDX_IRQ_STAT, 8'h02);
		end
		repeat (4) @(posedge ref_clk);
		report_and_stop;
	end
endmodule

bind deeac_top deeac_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_deeac_checker (.ref_clk,
	.sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .external_reset_pin, .watchdog_timer_rst, .irq_o);
